//--- logic/flash_protect_erase_ctrl.sv
// flash lock, sector protection, program and erase sequencing
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_protect_erase_ctrl
  import flash_pkg::*;
#(
  parameter int FLASH_BYTES    = `FLASH_BYTES_DEF,
  parameter int PAGE_BYTES     = `PAGE_BYTES_DEF,
  parameter int PAGE_ERASE_CYC = `PAGE_ERASE_CYC,
  parameter int MASS_ERASE_CYC = `MASS_ERASE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        dbg_access,
  output logic [7:0]       reg_rdata,
  // option bit and core
  input  wire logic        write_protect_option_bit,
  output logic             cpu_stall,
  // program-memory byte writes from the core
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  // bypass pins
  input  wire logic        bypass_en,
  input  wire logic        ext_prog,
  input  wire logic        ext_perase,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_data,
  // array control
  output logic             arr_prog,
  output logic             arr_perase,
  output logic             arr_merase,
  output logic [15:0]      arr_addr,
  output logic [7:0]       arr_data
);

  // ==========================================
  // state register
  ctrl_state_t q;
  ctrl_state_t next_q;

  logic wr_ctrl;
  logic wr_page;
  logic rd_ctrl;
  logic rd_page;
  logic rd_status;
  logic page_blocked;
  logic byte_blocked;
  logic page_match;
  logic busy;
  logic [7:0] status_byte;
  logic [7:0] byte_page;

  // ==========================================
  // address decode
  assign wr_ctrl   = reg_wr && (reg_addr == `REG_CTRL_ADDR);
  assign wr_page   = reg_wr && (reg_addr == `REG_PAGE_ADDR);
  assign rd_ctrl   = reg_rd && (reg_addr == `REG_CTRL_ADDR);
  assign rd_page   = reg_rd && (reg_addr == `REG_PAGE_ADDR);
  assign rd_status = reg_rd && (reg_addr == `REG_STATUS_ADDR);

  // ==========================================
  // protection lookups
  flash_sector_check #(
    .FLASH_BYTES (FLASH_BYTES),
    .PAGE_BYTES  (PAGE_BYTES)
  ) u_page_check (
    .page         (q.page_sel),
    .sect_prot    (q.sect_prot),
    .page_blocked (page_blocked)
  );

  assign byte_page = 8'(mem_addr >> `PAGE_SHIFT);

  flash_sector_check #(
    .FLASH_BYTES (FLASH_BYTES),
    .PAGE_BYTES  (PAGE_BYTES)
  ) u_byte_check (
    .page         (byte_page),
    .sect_prot    (q.sect_prot),
    .page_blocked (byte_blocked)
  );

  assign page_match = (byte_page == q.page_sel);

  // ==========================================
  // status view
  assign busy = (q.st == ST_PAGE_ERASE) || (q.st == ST_MASS_ERASE);

  always_comb begin
    status_byte = 8'h00;
    status_byte[`STAT_BUSY_BIT] = busy;
    status_byte[`STAT_SECT_BIT] = q.sect_mode;
    status_byte[`STAT_STATE_LSB +: 3] = q.st;
  end

  // ==========================================
  // next state
  always_comb begin
    next_q        = q;
    next_q.prog   = 1'b0;
    next_q.rdata  = 8'h00;

    // read data stands for one cycle only
    if (rd_status) begin
      next_q.rdata = status_byte;
    end else if (rd_page) begin
      if (q.sect_mode) begin
        next_q.rdata = q.sect_prot;
      end else begin
        next_q.rdata = q.page_sel;
      end
    end else if (rd_ctrl) begin
      next_q.rdata = status_byte;
    end

    case (q.st)
      ST_PAGE_ERASE,
      ST_MASS_ERASE: begin
        // register writes ignored while erasing
        if (q.cnt == 16'h0000) begin
          next_q.st     = ST_LOCKED;
          next_q.stall  = 1'b0;
          next_q.perase = 1'b0;
          next_q.merase = 1'b0;
        end else begin
          next_q.cnt = q.cnt - 16'h0001;
        end
      end

      default: begin
        // ----- shared page / sector register
        if (wr_page) begin
          if (q.sect_mode) begin
            // bits only accumulate; clearing needs a reset
            next_q.sect_prot = q.sect_prot | reg_wdata;
          end else begin
            next_q.page_sel = reg_wdata;
            case (q.st)
              ST_LOCKED: begin
                next_q.first_page = reg_wdata;
              end
              ST_GOT_KEY2: begin
                if (reg_wdata == q.first_page) begin
                  next_q.st = ST_ACTIVE;
                end else begin
                  next_q.st = ST_LOCKED;
                end
              end
              default: begin
                next_q.st = ST_LOCKED;
              end
            endcase
          end
        end

        // ----- control register
        if (wr_ctrl) begin
          if (reg_wdata == `CMD_SECT_SELECT) begin
            next_q.sect_mode = 1'b1;
            if (q.st != ST_ACTIVE) begin
              next_q.st = ST_LOCKED;
            end
          end else begin
            next_q.sect_mode = 1'b0;
            case (q.st)
              ST_LOCKED: begin
                if (reg_wdata == `CMD_KEY1) begin
                  next_q.st = ST_GOT_KEY1;
                end
              end
              ST_GOT_KEY1: begin
                if (reg_wdata == `CMD_KEY2) begin
                  next_q.st = ST_GOT_KEY2;
                end else begin
                  next_q.st = ST_LOCKED;
                end
              end
              ST_ACTIVE: begin
                if (reg_wdata == `CMD_PAGE_ERASE
                    && write_protect_option_bit
                    && !dbg_access_blocks_page()
                    && !page_blocked) begin
                  next_q.st     = ST_PAGE_ERASE;
                  next_q.cnt    = 16'(PAGE_ERASE_CYC - 1);
                  next_q.stall  = 1'b1;
                  next_q.perase = 1'b1;
                  next_q.addr   = 16'({q.page_sel, {`PAGE_SHIFT{1'b0}}});
                  next_q.data   = `ERASED_BYTE;
                end else if (reg_wdata == `CMD_MASS_ERASE && dbg_access) begin
                  next_q.st     = ST_MASS_ERASE;
                  next_q.cnt    = 16'(MASS_ERASE_CYC - 1);
                  next_q.stall  = 1'b1;
                  next_q.merase = 1'b1;
                  next_q.addr   = 16'h0000;
                  next_q.data   = `ERASED_BYTE;
                end else begin
                  next_q.st = ST_LOCKED;
                end
              end
              default: begin
                next_q.st = ST_LOCKED;
              end
            endcase
          end
        end

        // ----- byte programming inside the active page
        if (q.st == ST_ACTIVE && mem_wr && !reg_wr && page_match
            && write_protect_option_bit && !byte_blocked) begin
          next_q.prog = 1'b1;
          next_q.addr = mem_addr;
          next_q.data = mem_wdata;
        end
      end
    endcase
  end

  // page erase has no debug restriction; kept as a hook for clarity
  function automatic logic dbg_access_blocks_page();
    dbg_access_blocks_page = 1'b0;
  endfunction : dbg_access_blocks_page

  // ==========================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q            <= '0;
      q.st         <= ST_LOCKED;
      q.page_sel   <= `PAGE_SEL_RST;
      q.sect_prot  <= `SECT_PROT_RST;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================
  // array control, optionally handed to the pins
  flash_array_mux u_mux (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .bypass_en  (bypass_en),
    .int_prog   (q.prog),
    .int_perase (q.perase),
    .int_merase (q.merase),
    .int_addr   (q.addr),
    .int_data   (q.data),
    .ext_prog   (ext_prog),
    .ext_perase (ext_perase),
    .ext_addr   (ext_addr),
    .ext_data   (ext_data),
    .arr_prog   (arr_prog),
    .arr_perase (arr_perase),
    .arr_merase (arr_merase),
    .arr_addr   (arr_addr),
    .arr_data   (arr_data)
  );

  assign reg_rdata = q.rdata;
  assign cpu_stall = q.stall;

endmodule : flash_protect_erase_ctrl

//--- logic/flash_ctrl_map.svh
// register offsets, command codes, field positions and erase timing
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

// ==========================================
// register offsets
`define REG_CTRL_ADDR     2'h0
`define REG_PAGE_ADDR     2'h1
`define REG_STATUS_ADDR   2'h2

// ==========================================
// control register command codes
`define CMD_KEY1          8'h73
`define CMD_KEY2          8'h8C
`define CMD_PAGE_ERASE    8'h95
`define CMD_MASS_ERASE    8'h63
`define CMD_SECT_SELECT   8'h5E

// ==========================================
// reset values and erased byte
`define PAGE_SEL_RST      8'h00
`define SECT_PROT_RST     8'h00
`define ERASED_BYTE       8'hFF

// ==========================================
// status register fields
`define STAT_BUSY_BIT     7
`define STAT_SECT_BIT     4
`define STAT_STATE_LSB    0

// ==========================================
// array geometry
`define FLASH_BYTES_DEF   8192
`define PAGE_BYTES_DEF    512
`define PAGE_SHIFT        9
`define MAX_SECTORS       8

// ==========================================
// erase timing
`define SYS_CLK_NS        40
`define PAGE_ERASE_NS     10000
`define MASS_ERASE_NS     200000
`define PAGE_ERASE_CYC    ((`PAGE_ERASE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define MASS_ERASE_CYC    ((`MASS_ERASE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

//--- logic/flash_pkg.sv
// types shared by the flash lock and erase controller
package flash_pkg;

  typedef enum logic [2:0] {
    ST_LOCKED,
    ST_GOT_KEY1,
    ST_GOT_KEY2,
    ST_ACTIVE,
    ST_PAGE_ERASE,
    ST_MASS_ERASE
  } state_t;

  typedef struct packed {
    state_t      st;
    logic [7:0]  first_page;
    logic [7:0]  page_sel;
    logic [7:0]  sect_prot;
    logic        sect_mode;
    logic [15:0] cnt;
    logic [7:0]  rdata;
    logic        stall;
    logic        prog;
    logic        perase;
    logic        merase;
    logic [15:0] addr;
    logic [7:0]  data;
  } ctrl_state_t;

  typedef struct packed {
    logic        prog;
    logic        perase;
    logic        merase;
    logic [15:0] addr;
    logic [7:0]  data;
  } arr_port_t;

endpackage : flash_pkg

//--- logic/flash_sector_check.sv
// sector lookup: tells whether a page lies in a protected sector
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_sector_check
  import flash_pkg::*;
#(
  parameter int FLASH_BYTES = `FLASH_BYTES_DEF,
  parameter int PAGE_BYTES  = `PAGE_BYTES_DEF
) (
  input  wire logic [7:0] page,
  input  wire logic [7:0] sect_prot,
  output logic            page_blocked
);
  // small arrays: sector never smaller than a page
  localparam int SECT_BYTES = (FLASH_BYTES / `MAX_SECTORS < PAGE_BYTES) ?
                              PAGE_BYTES : FLASH_BYTES / `MAX_SECTORS;
  localparam int PAGES_PER_SECT = SECT_BYTES / PAGE_BYTES;
  localparam int NUM_PAGES      = FLASH_BYTES / PAGE_BYTES;

  logic [`MAX_SECTORS-1:0] hit;

  // ==========================================
  // per-sector match
  for (genvar i = 0; i < `MAX_SECTORS; i++) begin : g_sect
    assign hit[i] = sect_prot[i] && (int'(page) / PAGES_PER_SECT == i);
  end

  // pages past the array count as blocked
  assign page_blocked = (|hit) || (int'(page) >= NUM_PAGES);
endmodule : flash_sector_check

//--- logic/flash_array_mux.sv
// registered selection of array control between controller and pins
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_array_mux
  import flash_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        bypass_en,
  input  wire logic        int_prog,
  input  wire logic        int_perase,
  input  wire logic        int_merase,
  input  wire logic [15:0] int_addr,
  input  wire logic [7:0]  int_data,
  input  wire logic        ext_prog,
  input  wire logic        ext_perase,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_data,
  output logic             arr_prog,
  output logic             arr_perase,
  output logic             arr_merase,
  output logic [15:0]      arr_addr,
  output logic [7:0]       arr_data
);
  arr_port_t q;
  arr_port_t next_q;

  // ==========================================
  // pin programmer wins while bypassed
  always_comb begin
    if (bypass_en) begin
      next_q = '{ext_prog, ext_perase, 1'b0, ext_addr, ext_data};
    end else begin
      next_q = '{int_prog, int_perase, int_merase, int_addr, int_data};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign arr_prog   = q.prog;
  assign arr_perase = q.perase;
  assign arr_merase = q.merase;
  assign arr_addr   = q.addr;
  assign arr_data   = q.data;
endmodule : flash_array_mux

//--- tb/flash_ctrl_props.sv
// port assertions for the flash lock and erase controller
`timescale 1ns/1ps
module flash_ctrl_props #(
  parameter int MASS_ERASE_CYC = 5000
) (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic [1:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        dbg_access,
  input wire logic [7:0]  reg_rdata,
  input wire logic        write_protect_option_bit,
  input wire logic        cpu_stall,
  input wire logic        mem_wr,
  input wire logic        bypass_en,
  input wire logic [15:0] ext_addr,
  input wire logic        arr_prog,
  input wire logic        arr_perase,
  input wire logic        arr_merase,
  input wire logic [15:0] arr_addr
);
  // ==========================================
  // helpers
  // a counter, since erase lengths are far beyond what repetition may unroll
  logic [15:0] stall_cnt;
  wire logic   idle_ctrl_wr = reg_wr && reg_addr == 2'h0 && !cpu_stall;
  always_ff @(posedge clk_sys) begin
    if (srst || !cpu_stall) stall_cnt <= 16'h0000;
    else stall_cnt <= stall_cnt + 16'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ==========================================
  // assertions
  reset_locked_a: assert property ($fell(srst) |-> !cpu_stall && reg_rdata == 8'h00)
    else $error("stall or read data left over after reset");
  status_busy_a: assert property (reg_rd && reg_addr == 2'h2 |=> reg_rdata[7] == $past(cpu_stall))
    else $error("status busy bit disagrees with stall");
  user_erase_a: assert property (idle_ctrl_wr && reg_wdata == 8'h95 && !write_protect_option_bit |=> !cpu_stall)
    else $error("page erase started with option bit low");
  user_mass_a: assert property (idle_ctrl_wr && reg_wdata == 8'h63 && !dbg_access |=> !cpu_stall)
    else $error("mass erase started from user code");
  stall_bound_a: assert property (cpu_stall |-> stall_cnt <= MASS_ERASE_CYC + 2)
    else $error("core stalled beyond erase length");
  erase_drive_a: assert property ($rose(cpu_stall) && !bypass_en |=> arr_perase || arr_merase)
    else $error("stall without erase on the array");
  page_align_a: assert property ($rose(arr_perase) && !$past(bypass_en) |-> arr_addr[8:0] == 9'h000)
    else $error("page erase address not page aligned");
  prog_refused_a: assert property (mem_wr && !write_protect_option_bit ##1 !bypass_en |=> !arr_prog)
    else $error("byte programmed with option bit low");
  bypass_copy_a: assert property (bypass_en ##1 bypass_en |-> arr_addr == $past(ext_addr) && !arr_merase)
    else $error("array control not taken from pins in bypass");
  cover property ($rose(cpu_stall));
  cover property (arr_prog && !bypass_en);
  cover property (arr_merase);
endmodule : flash_ctrl_props

//--- tb/core_bus_model.sv
// processor and debugger model driving the register port and byte writes
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module core_bus_model (
  input wire logic [7:0] reg_rdata,
  input wire logic       clk_sys,
  output logic [1:0]     reg_addr,
  output logic [7:0]     reg_wdata,
  output logic           reg_wr,
  output logic           reg_rd,
  output logic           dbg_access,
  output logic           mem_wr,
  output logic [15:0]    mem_addr,
  output logic [7:0]     mem_wdata
);
  // ==========================================
  // bus cycles
  // data lines are inverted after release so stale values never look valid
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, dbg_access} = '0;
    {mem_wr, mem_addr, mem_wdata} = '0;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic dbg);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    dbg_access <= dbg;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // a differing second page is how a scenario asks for a broken sequence
  task automatic unlock(input logic [7:0] p, input logic [7:0] p2);
    wr(`REG_PAGE_ADDR, p, 1'b0);
    wr(`REG_CTRL_ADDR, `CMD_KEY1, 1'b0);
    wr(`REG_CTRL_ADDR, `CMD_KEY2, 1'b0);
    wr(`REG_PAGE_ADDR, p2, 1'b0);
  endtask : unlock
  // callers write each byte once between erases
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge clk_sys);
    mem_wr <= 1'b0;
    mem_wdata <= ~d;
  endtask : prog
endmodule : core_bus_model

//--- tb/flash_protect_erase_ctrl_test.sv
// self-checking bench for the flash lock, protection and erase controller
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
bind flash_protect_erase_ctrl flash_ctrl_props #(.MASS_ERASE_CYC(MASS_ERASE_CYC)) flash_ctrl_props_inst (
  .clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .dbg_access, .reg_rdata, .write_protect_option_bit,
  .cpu_stall, .mem_wr, .bypass_en, .ext_addr, .arr_prog, .arr_perase, .arr_merase, .arr_addr);
module flash_protect_erase_ctrl_test;
  // ==========================================
  // design and model
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic write_protect_option_bit = 1'b1;
  logic bypass_en = 1'b0;
  logic ext_prog = 1'b0;
  logic ext_perase = 1'b0;
  logic [15:0] ext_addr = 16'h0000;
  logic [7:0] ext_data = 8'h00;
  wire [1:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata, mem_wdata, arr_data;
  wire [15:0] mem_addr, arr_addr;
  wire reg_wr, reg_rd, dbg_access, mem_wr, cpu_stall, arr_prog, arr_perase, arr_merase;
  int n_errors = 0;
  int tests_run = 0;
  int polls;
  always #20 clk_sys = ~clk_sys;
  // short erase counts keep the run small
  flash_protect_erase_ctrl #(.PAGE_ERASE_CYC(4), .MASS_ERASE_CYC(4)) flash_protect_erase_ctrl_inst (
    .clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .dbg_access, .reg_rdata, .write_protect_option_bit,
    .cpu_stall, .mem_wr, .mem_addr, .mem_wdata, .bypass_en, .ext_prog, .ext_perase, .ext_addr, .ext_data,
    .arr_prog, .arr_perase, .arr_merase, .arr_addr, .arr_data);
  core_bus_model core_bus_model_inst (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .dbg_access, .mem_wr, .mem_addr, .mem_wdata);
  // ==========================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic expect_reg(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    core_bus_model_inst.rd(a, d);
    check(d, exp);
  endtask : expect_reg
  // debugger polling, bounded so a stuck erase ends the run
  task automatic poll_idle();
    logic [7:0] d;
    polls = 0;
    do begin
      core_bus_model_inst.rd(`REG_STATUS_ADDR, d);
      polls++;
    end while (d[`STAT_BUSY_BIT] !== 1'b0 && polls < 50);
    if (polls >= 50) begin
      n_errors++;
      final_report();
    end
  endtask : poll_idle
  task automatic ctrl(input logic [7:0] d, input logic dbg);
    core_bus_model_inst.wr(`REG_CTRL_ADDR, d, dbg);
    #1;
  endtask : ctrl
  // ==========================================
  // scenarios
  task automatic test_reset();
    expect_reg(`REG_STATUS_ADDR, 8'h00);
    core_bus_model_inst.wr(2'h3, 8'hFF, 1'b0);
    expect_reg(2'h3, 8'h00);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_program();
    logic [23:0] hit;
    hit = 24'h00_0000;
    core_bus_model_inst.unlock(8'h05, 8'h06);
    expect_reg(`REG_STATUS_ADDR, 8'h00);
    core_bus_model_inst.unlock(8'h02, 8'h02);
    expect_reg(`REG_STATUS_ADDR, 8'h03);
    core_bus_model_inst.prog(16'h0405, 8'hA5);
    repeat (4) begin
      @(posedge clk_sys);
      #1 if (arr_prog === 1'b1) hit = {arr_addr, arr_data};
    end
    check(hit, 24'h04_05A5);
    expect_reg(`REG_STATUS_ADDR, 8'h03);
    ctrl(8'h11, 1'b0);
    expect_reg(`REG_STATUS_ADDR, 8'h00);
    $display("test_program done");
  endtask : test_program
  task automatic test_page_erase();
    core_bus_model_inst.unlock(8'h03, 8'h03);
    ctrl(`CMD_PAGE_ERASE, 1'b0);
    check(cpu_stall, 1'b1);
    @(posedge clk_sys);
    #1 check({arr_perase, arr_addr}, {1'b1, 16'h0600});
    poll_idle();
    check(polls > 1, 1'b1);
    check(cpu_stall, 1'b0);
    @(posedge clk_sys);
    #1 check(arr_perase, 1'b0);
    expect_reg(`REG_STATUS_ADDR, 8'h00);
    $display("test_page_erase done");
  endtask : test_page_erase
  task automatic test_protect();
    ctrl(`CMD_SECT_SELECT, 1'b0);
    expect_reg(`REG_STATUS_ADDR, 8'h10);
    core_bus_model_inst.wr(`REG_PAGE_ADDR, 8'h02, 1'b0);
    core_bus_model_inst.wr(`REG_PAGE_ADDR, 8'h00, 1'b0);
    expect_reg(`REG_PAGE_ADDR, 8'h02);
    ctrl(8'h00, 1'b0);
    core_bus_model_inst.unlock(8'h03, 8'h03);
    ctrl(`CMD_PAGE_ERASE, 1'b0);
    check(cpu_stall, 1'b0);
    expect_reg(`REG_STATUS_ADDR, 8'h00);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    ctrl(`CMD_SECT_SELECT, 1'b0);
    expect_reg(`REG_PAGE_ADDR, 8'h00);
    ctrl(8'h00, 1'b0);
    $display("test_protect done");
  endtask : test_protect
  task automatic test_option_low();
    @(posedge clk_sys);
    write_protect_option_bit <= 1'b0;
    core_bus_model_inst.unlock(8'h04, 8'h04);
    core_bus_model_inst.prog(16'h0810, 8'h3C);
    ctrl(`CMD_PAGE_ERASE, 1'b0);
    check(cpu_stall, 1'b0);
    core_bus_model_inst.unlock(8'h04, 8'h04);
    ctrl(`CMD_MASS_ERASE, 1'b0);
    check(cpu_stall, 1'b0);
    core_bus_model_inst.unlock(8'h04, 8'h04);
    ctrl(`CMD_MASS_ERASE, 1'b1);
    check(cpu_stall, 1'b1);
    @(posedge clk_sys);
    #1 check(arr_merase, 1'b1);
    poll_idle();
    expect_reg(`REG_STATUS_ADDR, 8'h00);
    @(posedge clk_sys);
    write_protect_option_bit <= 1'b1;
    $display("test_option_low done");
  endtask : test_option_low
  task automatic test_bypass();
    @(posedge clk_sys);
    bypass_en <= 1'b1;
    ext_prog <= 1'b1;
    ext_addr <= 16'h1234;
    ext_data <= 8'h5A;
    @(posedge clk_sys);
    ext_prog <= 1'b0;
    #1 check({arr_prog, arr_merase, arr_addr, arr_data}, {2'b10, 16'h1234, 8'h5A});
    @(posedge clk_sys);
    bypass_en <= 1'b0;
    $display("test_bypass done");
  endtask : test_bypass
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    test_reset();
    test_program();
    test_page_erase();
    test_protect();
    test_option_low();
    test_bypass();
    final_report();
  end
endmodule : flash_protect_erase_ctrl_test
